// ### rtl/gdh_consts.svh
// Constants of the gate-driver host controller: register map, fields, timing.
// Assumes a 25 MHz system clock and 32-bit APB access by software.
// Behaviour
// - Bootstrap charges only while the low side is on; low on-time must be scheduled.
// - After enabling, drive both commands low before the first high-side command.
// - Initial charge lasts longer than 0.3 ms plus 1.1 times capacitance in uF over 2.2.
// - Let the bootstrap reach steady state before normal high-side switching.
`ifndef GDH_CONSTS_SVH
`define GDH_CONSTS_SVH

`define GDH_ADDR_CTRL 8'h00
`define GDH_ADDR_PHASE 8'h04
`define GDH_ADDR_DEAD 8'h08
`define GDH_ADDR_STATUS 8'h0c

`define GDH_CTRL_START_BIT 0
`define GDH_DEAD_RESET 8'h04

`define GDH_CLK_MHZ 25
`define GDH_CHARGE_BASE_US 300
// Half a microsecond per nanofarad: 1.1 / 2.2 ms per uF
`define GDH_CHARGE_NF_PER_US 2
`define GDH_BOOT_CAP_NF 2200

`endif

// ### rtl/gdh_pkg.sv
// Types of the gate-driver host controller.
// Assumes gdh_consts.svh for every numeric constant.
package gdh_pkg;
   typedef enum logic [2:0] {
      GDH_IDLE = 3'b001,
      GDH_CHARGE = 3'b010,
      GDH_RUN = 3'b100
   } gdh_state_e;

   // Requested drive of one phase
   typedef enum logic [1:0] {
      GDH_PH_OFF = 2'b00,
      GDH_PH_LOW = 2'b01,
      GDH_PH_HIGH = 2'b10
   } gdh_phase_e;

   typedef struct packed {
      gdh_state_e st;
      logic [31:0] cnt;
      logic en;
      logic [2:0] hs;
      logic [2:0] lsn;
      logic [2:0][1:0] applied;
      logic [2:0][7:0] dcnt;
      logic [2:0][1:0] want;
      logic [7:0] dead_cfg;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } gdh_regs_s;
endpackage : gdh_pkg

// ### rtl/gdh_host.sv
// Host-side controller that drives a three-phase gate driver's command pins.
// Assumes software on APB; the driver's lock-outs act inside the driver itself.
`timescale 1ns/10ps
`include "gdh_consts.svh"
module gdh_host
   import gdh_pkg::*;
#(
   parameter int unsigned BOOT_CAP_NF = `GDH_BOOT_CAP_NF,
   // Cycles of initial low-side charging; strictly longer than the minimum when BOOT_CAP_NF is even
   parameter int unsigned CHARGE_CYCLES =
      (`GDH_CHARGE_BASE_US + BOOT_CAP_NF / `GDH_CHARGE_NF_PER_US) * `GDH_CLK_MHZ + 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   // Gate driver commands
   output logic drv_enable,
   output logic [2:0] high_side_cmd,
   output logic [2:0] low_side_cmd_n
);

   gdh_regs_s r_r;
   gdh_regs_s r_nxt;

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == `GDH_ADDR_CTRL) || (a == `GDH_ADDR_PHASE) ||
                (a == `GDH_ADDR_DEAD) || (a == `GDH_ADDR_STATUS);
   endfunction : addr_ok

   logic wr_ok;
   logic start_wr;
   logic stop_wr;
   assign wr_ok = psel & penable & r_r.pready & pwrite & addr_ok(paddr);
   assign start_wr = wr_ok & (paddr == `GDH_ADDR_CTRL) & pwdata[`GDH_CTRL_START_BIT];
   assign stop_wr = wr_ok & (paddr == `GDH_ADDR_CTRL) & ~pwdata[`GDH_CTRL_START_BIT];

   always_comb begin
      r_nxt = r_r;
      // Zero-wait slave: ready in the first access cycle, data latched at setup
      r_nxt.pready = psel & ~penable;
      r_nxt.pslverr = psel & ~penable & ~addr_ok(paddr);
      if (psel && !penable) begin
         unique case (paddr)
            `GDH_ADDR_CTRL: r_nxt.prdata = {31'h0, r_r.st != GDH_IDLE};
            `GDH_ADDR_PHASE: r_nxt.prdata = {26'h0, r_r.want};
            `GDH_ADDR_DEAD: r_nxt.prdata = {24'h0, r_r.dead_cfg};
            `GDH_ADDR_STATUS: r_nxt.prdata = {25'h0, r_r.hs, r_r.st, 1'b0};
            default: r_nxt.prdata = 32'h0;
         endcase
      end
      if (wr_ok && paddr == `GDH_ADDR_PHASE) begin
         r_nxt.want = pwdata[5:0];
      end
      if (wr_ok && paddr == `GDH_ADDR_DEAD) begin
         r_nxt.dead_cfg = pwdata[7:0];
      end

      unique case (r_r.st)
         GDH_IDLE: begin
            r_nxt.en = 1'b0;
            r_nxt.cnt = 32'h0;
            for (int p = 0; p < 3; p++) begin
               r_nxt.applied[p] = GDH_PH_OFF;
               r_nxt.dcnt[p] = 8'h0;
            end
            if (start_wr) begin
               r_nxt.st = GDH_CHARGE;
               r_nxt.en = 1'b1;
            end
         end
         GDH_CHARGE: begin
            // Low side on in every phase so each bootstrap fills before any high side
            for (int p = 0; p < 3; p++) begin
               r_nxt.applied[p] = GDH_PH_LOW;
            end
            r_nxt.cnt = r_r.cnt + 32'h1;
            if (r_r.cnt == CHARGE_CYCLES[31:0] - 32'h1) begin
               r_nxt.st = GDH_RUN;
            end
         end
         GDH_RUN: begin
            // Host gap on top of the driver's own minimum; the driver keeps the longer
            for (int p = 0; p < 3; p++) begin
               if (r_r.applied[p] != r_r.want[p]) begin
                  if (r_r.applied[p] != GDH_PH_OFF) begin
                     r_nxt.applied[p] = GDH_PH_OFF;
                     r_nxt.dcnt[p] = r_r.dead_cfg;
                  end else if (r_r.dcnt[p] != 8'h0) begin
                     r_nxt.dcnt[p] = r_r.dcnt[p] - 8'h1;
                  end else begin
                     r_nxt.applied[p] = r_r.want[p];
                  end
               end
            end
         end
      endcase
      if (stop_wr) begin
         r_nxt.st = GDH_IDLE;
         r_nxt.en = 1'b0;
         for (int p = 0; p < 3; p++) begin
            r_nxt.applied[p] = GDH_PH_OFF;
         end
      end

      // Pin encoding: off is 0/1, low is 0/0, high is 1/1
      for (int p = 0; p < 3; p++) begin
         r_nxt.hs[p] = r_nxt.applied[p] == GDH_PH_HIGH;
         r_nxt.lsn[p] = r_nxt.applied[p] != GDH_PH_LOW;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r_r <= '{st: GDH_IDLE, cnt: 32'h0, en: 1'b0, hs: 3'h0, lsn: 3'h7,
                  applied: '0, dcnt: '0, want: '0, dead_cfg: `GDH_DEAD_RESET,
                  pready: 1'b0, pslverr: 1'b0, prdata: 32'h0};
      end else begin
         r_r <= r_nxt;
      end
   end

   assign pready = r_r.pready;
   assign pslverr = r_r.pslverr;
   assign prdata = r_r.prdata;
   assign drv_enable = r_r.en;
   assign high_side_cmd = r_r.hs;
   assign low_side_cmd_n = r_r.lsn;

endmodule : gdh_host

// ### verif/gdh_host_properties.sv
// Port checker for gdh_host, bound to every instance.
// Assumes the charge count is handed on from the instance.
`timescale 1ns/10ps
module gdh_host_properties #(parameter int unsigned CHARGE_CYCLES = 20) (
   input wire logic clk, rst_b, psel, penable, pwrite, pready, pslverr, drv_enable,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic [2:0] high_side_cmd, low_side_cmd_n
);
   int unsigned en_cnt_r;
   // Saturates so a long run never wraps under the bound
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) en_cnt_r <= 0;
      else en_cnt_r <= !drv_enable ? 0 : en_cnt_r + (en_cnt_r <= CHARGE_CYCLES);
   end
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not one cycle after setup");
   a_apb_err: assert property (psel && penable && pready && paddr > 8'h0c |-> pslverr)
      else $error("unmapped access not refused");
   a_off_disabled: assert property (!drv_enable |-> !high_side_cmd && &low_side_cmd_n)
      else $error("commands active while disabled");
   a_low_first: assert property ($rose(drv_enable) |-> !high_side_cmd ##1
      (low_side_cmd_n == 3'h0 && high_side_cmd == 3'h0)[*8]) else $error("no initial charge");
   a_charge_time: assert property (high_side_cmd != 3'h0 |-> en_cnt_r > CHARGE_CYCLES)
      else $error("high side before charge time");
   a_stop_clears: assert property (psel && penable && pready && pwrite && paddr == 8'h00
      && !pwdata[0] |=> !drv_enable) else $error("stop ignored");
endmodule : gdh_host_properties
bind gdh_host gdh_host_properties #(.CHARGE_CYCLES(CHARGE_CYCLES)) gdh_host_properties_i (.*);

// ### verif/gdh_drv_model.sv
// Behavioural three-phase gate driver seen by the host.
// Assumes fault stands for all lock-outs ORed together.
`timescale 1ns/10ps
module gdh_drv_model (
   input wire logic clk, rst_b, en, fault,
   input wire logic [2:0] hs, lsn,
   output logic [2:0] gh, gl
);
   logic [2:0] boot_ok_r;
   logic [2:0] h_raw;
   logic [2:0] l_raw;
   logic [2:0] gh_r;
   logic [2:0] gl_r;
   // Previous gate levels: a side may not turn on straight after the other was on
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gh_r <= 3'h0;
         gl_r <= 3'h0;
      end else begin
         gh_r <= gh;
         gl_r <= gl;
      end
   end
   // Bootstrap charges only through an on low side
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) boot_ok_r <= 3'h0;
      else boot_ok_r <= boot_ok_r | gl;
   end
   assign h_raw = {3{en & ~fault}} & hs & lsn & boot_ok_r;
   assign l_raw = {3{en & ~fault}} & ~hs & ~lsn;
   assign gh = h_raw & ~gl_r;
   assign gl = l_raw & ~gh_r;
endmodule : gdh_drv_model

// ### verif/gdh_host_tb.sv
// Self-checking bench for gdh_host with a gate driver model.
// Assumes a short charge count for simulation.
`timescale 1ns/10ps
module gdh_host_tb;
   logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, fault = 0, e;
   logic pready, pslverr, drv_enable;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [2:0] high_side_cmd, low_side_cmd_n, gh, gl;
   int error_cnt = 0, check_count = 0, n;
   always #20 clk = ~clk;
   gdh_host #(.CHARGE_CYCLES(20)) gdh_host_i (.*);
   gdh_drv_model gdh_drv_model_i (.clk, .rst_b, .en(drv_enable), .fault,
      .hs(high_side_cmd), .lsn(low_side_cmd_n), .gh, .gl);
   task finish_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin error_cnt++; finish_test; end
      rd = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task t_regs;
      chk({drv_enable, high_side_cmd, low_side_cmd_n, gh, gl}, 32'h1c0);
      apb(0, 8'h08, 0); chk(rd, 32'h4);
      apb(1, 8'h08, 32'h2); apb(0, 8'h08, 0); chk(rd, 32'h2);
      apb(1, 8'h10, 32'h1); chk(e, 1);
      apb(0, 8'h0c, 0); chk(rd[3:1], 3'h1);
      $display("regs done");
   endtask : t_regs
   task t_run;
      int off_n;
      apb(1, 8'h00, 1);
      apb(1, 8'h04, 32'h6);
      repeat (4) @(posedge clk);
      chk({gh, gl}, 6'h07);
      fault <= 1;
      repeat (2) @(posedge clk);
      chk(gl, 3'h0);
      fault <= 0;
      off_n = 0;
      // Count phase 0 off cycles between its low gate falling and its high gate rising
      for (int i = 0; i < 100 && gh[0] !== 1'b1; i++) begin
         @(posedge clk);
         if (gl[0] === 1'b1) off_n = 0;
         else if (gh[0] !== 1'b1) off_n++;
      end
      chk({gh, gl}, 6'h0a);
      chk(off_n, 3);
      apb(0, 8'h0c, 0); chk(rd[3:1], 3'h4);
      chk(rd[6:4], 3'h1);
      apb(1, 8'h00, 0); @(posedge clk); chk({drv_enable, gh, gl}, 0);
      $display("run done");
   endtask : t_run
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1;
      t_regs;
      t_run;
      finish_test;
   end
endmodule : gdh_host_tb
